// ---- hw/dcr_pkg.sv ----
// Constants, types and register map of the burst-read core
// What this block does
// - A started burst runs to its end; length chosen per command if enabled.
// - Read strobe preamble lasts 2 clocks, static or toggling by setting.
// - Strobe postamble lasts half a clock, or 1.5 clocks when extended.
// - Two lowest column bits are zero, so bursts start on multiples of four.
// - Read latency counts from the edge completing the second column cycle.
// - First data bit on first rising strobe edge after preamble, then each edge.
// - A read command at a rising clock edge while idle, with select still high at the next rising edge, starts a burst.
package dcr_pkg;
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_STAT   = 8'h04;
  localparam logic [7:0]  OFF_COUNT  = 8'h08;
  localparam logic [1:0]  PAT_PAGE   = 2'h1;
  localparam logic [7:0]  CTRL_RESET = 8'h06;
  localparam logic [4:0]  OP_READ    = 5'h02;
  localparam logic [3:0]  MIN_READ_LATENCY = 4'h3;
  localparam logic [4:0]  PRE_HALVES      = 5'h04;
  localparam logic [4:0]  POST_STD_HALVES = 5'h01;
  localparam logic [4:0]  POST_EXT_HALVES = 5'h03;
  localparam logic [4:0]  SHORT_BEATS     = 5'h10;
  localparam logic [5:0]  LONG_BEATS      = 6'h20;

  typedef struct packed {
    logic       ext_postamble;
    logic       toggle_preamble;
    logic       long_burst;
    logic       otf_enable;
    logic [3:0] read_latency;
  } dcr_ctrl_t;

  typedef struct packed {
    logic       ck;
    logic       sel;
    logic [5:0] cmd_addr;
  } dcr_link_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CAS2 = 6'b000010,
    ST_LAT  = 6'b000100,
    ST_PRE  = 6'b001000,
    ST_DATA = 6'b010000,
    ST_POST = 6'b100000
  } dcr_state_t;
endpackage

// ---- hw/dcr_sync.sv ----
// Two-stage synchroniser for the link pins
`timescale 1ns/10ps
module dcr_sync #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// ---- hw/dcr_pat_ram.sv ----
// Read-data pattern store: one write port, two read ports
`timescale 1ns/10ps
module dcr_pat_ram #(
  parameter int DEPTH = 16,
  parameter int W     = 8,
  parameter int AW    = 4
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic [AW-1:0] i_raddr_a,
  output logic      [W-1:0]  o_rdata_a,
  input  wire logic [AW-1:0] i_raddr_b,
  output logic      [W-1:0]  o_rdata_b
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge i_clk)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
  end

  assign o_rdata_a = mem[i_raddr_a];
  assign o_rdata_b = mem[i_raddr_b];
endmodule

// ---- hw/dcr_top.sv ----
// Burst-read core: command capture, latency, strobe and data drive
`timescale 1ns/10ps
module dcr_top #(
  parameter int DQ_W      = 8,
  parameter int PAT_DEPTH = 16
) (
  input  wire logic            i_clk,
  input  wire logic            i_arst_n,
  input  wire logic [7:0]      i_paddr,
  input  wire logic            i_psel,
  input  wire logic            i_penable,
  input  wire logic            i_pwrite,
  input  wire logic [31:0]     i_pwdata,
  output logic      [31:0]     o_prdata,
  output logic                 o_pready,
  output logic                 o_pslverr,
  input  wire logic            i_ck,
  input  wire logic            i_cmd_sel,
  input  wire logic [5:0]      i_cmd_addr,
  output logic                 o_dqs_t,
  output logic                 o_dqs_c,
  output logic                 o_dqs_oe,
  output logic      [DQ_W-1:0] o_dq,
  output logic                 o_dq_oe
);
  localparam int PAT_AW = $clog2(PAT_DEPTH);

  if (DQ_W < 1 || DQ_W > 32)
    $error("DQ_W must lie in 1..32");
  if (PAT_DEPTH < 2 || PAT_DEPTH > 16 || (1 << PAT_AW) != PAT_DEPTH)
    $error("PAT_DEPTH must be a power of two in 2..16");

  // Link pins into the local clock
  dcr_pkg::dcr_link_t link_raw;
  dcr_pkg::dcr_link_t link_s;
  logic [7:0]         link_sync;

  assign link_raw = '{ck: i_ck, sel: i_cmd_sel, cmd_addr: i_cmd_addr};

  dcr_sync #(
    .W (8)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  (link_raw),
    .o_sync   (link_sync)
  );

  assign link_s = dcr_pkg::dcr_link_t'(link_sync);

  logic ck_q;
  wire  ck_rise = link_s.ck & ~ck_q;
  wire  ck_edge = link_s.ck ^ ck_q;

  // State and registers
  dcr_pkg::dcr_state_t st_q;
  dcr_pkg::dcr_state_t st_d;
  dcr_pkg::dcr_ctrl_t  ctrl_q;
  logic [4:0]          h_q;
  logic [4:0]          h_d;
  logic [3:0]          lat_q;
  logic [3:0]          lat_d;
  logic [7:0]          col_q;
  logic                long_q;
  logic                cmd_long_q;
  logic                refused_q;
  logic [15:0]         count_q;
  logic [31:0]         prdata_q;
  logic                pslverr_q;
  logic                dqs_q;
  logic                dqs_oe_q;
  logic [DQ_W-1:0]     dq_q;
  logic                dq_oe_q;

  // Command decode
  wire rd_cmd   = ck_rise & link_s.sel &
                  (link_s.cmd_addr[4:0] == dcr_pkg::OP_READ);
  wire busy     = (st_q != dcr_pkg::ST_IDLE);
  wire rd_first = rd_cmd & ~busy;
  wire refuse   = rd_cmd & busy & (st_q != dcr_pkg::ST_CAS2);
  wire cas_done = (st_q == dcr_pkg::ST_CAS2) & ck_rise & link_s.sel;

  // Effective latency never below what the preamble needs
  wire [3:0] lat_eff = (ctrl_q.read_latency < dcr_pkg::MIN_READ_LATENCY) ?
                       dcr_pkg::MIN_READ_LATENCY : ctrl_q.read_latency;
  wire [3:0] pre_at  = lat_eff - 4'h2;
  wire [3:0] lat_inc = lat_q + 4'h1;
  wire [4:0] beat_last = long_q ? 5'(dcr_pkg::LONG_BEATS - 6'h01) :
                         dcr_pkg::SHORT_BEATS - 5'h01;
  wire [4:0] post_last = ctrl_q.ext_postamble ?
                         dcr_pkg::POST_EXT_HALVES - 5'h01 :
                         dcr_pkg::POST_STD_HALVES - 5'h01;
  wire [4:0] pre_last  = dcr_pkg::PRE_HALVES - 5'h01;

  always_comb
  begin
    st_d  = st_q;
    h_d   = h_q;
    lat_d = lat_q;
    case (st_q)
      dcr_pkg::ST_IDLE:
        if (rd_first)
          st_d = dcr_pkg::ST_CAS2;
      dcr_pkg::ST_CAS2:
        if (ck_rise)
        begin
          st_d  = link_s.sel ? dcr_pkg::ST_LAT : dcr_pkg::ST_IDLE;
          lat_d = 4'h0;
        end
      dcr_pkg::ST_LAT:
        if (ck_rise)
        begin
          lat_d = lat_inc;
          if (lat_inc == pre_at)
          begin
            st_d = dcr_pkg::ST_PRE;
            h_d  = 5'h00;
          end
        end
      dcr_pkg::ST_PRE:
        if (ck_edge)
        begin
          h_d = h_q + 5'h01;
          if (h_q == pre_last)
          begin
            st_d = dcr_pkg::ST_DATA;
            h_d  = 5'h00;
          end
        end
      dcr_pkg::ST_DATA:
        if (ck_edge)
        begin
          h_d = h_q + 5'h01;
          if (h_q == beat_last)
          begin
            st_d = dcr_pkg::ST_POST;
            h_d  = 5'h00;
          end
        end
      dcr_pkg::ST_POST:
        if (ck_edge)
        begin
          h_d = h_q + 5'h01;
          if (h_q == post_last)
            st_d = dcr_pkg::ST_IDLE;
        end
      default:
        st_d = dcr_pkg::ST_IDLE;
    endcase
  end

  // Pin values for the next half cycle
  wire in_burst_d = (st_d == dcr_pkg::ST_PRE) | (st_d == dcr_pkg::ST_DATA) |
                    (st_d == dcr_pkg::ST_POST);
  wire dqs_d = (st_d == dcr_pkg::ST_DATA) ? ~h_d[0] :
               ((st_d == dcr_pkg::ST_PRE) & ctrl_q.toggle_preamble) ?
               ~h_d[0] : 1'b0;
  wire [PAT_AW-1:0] beat_idx = col_q[PAT_AW-1:0] + h_d[PAT_AW-1:0];
  logic [DQ_W-1:0]  beat_data;
  logic [DQ_W-1:0]  apb_pat;

  // Register decode
  wire apb_setup = i_psel & ~i_penable;
  wire apb_wr    = i_psel & i_penable & i_pwrite;
  wire aligned   = (i_paddr[1:0] == 2'b00);
  wire sel_ctrl  = (i_paddr == dcr_pkg::OFF_CTRL);
  wire sel_stat  = (i_paddr == dcr_pkg::OFF_STAT);
  wire sel_count = (i_paddr == dcr_pkg::OFF_COUNT);
  wire sel_pat   = (i_paddr[7:6] == dcr_pkg::PAT_PAGE) & aligned &
                   ({1'b0, i_paddr[5:2]} < 5'(PAT_DEPTH));
  wire map_hit   = sel_ctrl | sel_stat | sel_count | sel_pat;
  wire [31:0] stat_word = {16'h0000, col_q, 5'h00, long_q, refused_q, busy};
  wire [31:0] rd_word   = sel_ctrl  ? {24'h00_0000, ctrl_q} :
                          sel_stat  ? stat_word :
                          sel_count ? {16'h0000, count_q} :
                          sel_pat   ? 32'(apb_pat) : 32'h0000_0000;
  wire clr_refused = apb_wr & sel_stat & i_pwdata[1];
  wire burst_done  = (st_q == dcr_pkg::ST_POST) & (st_d == dcr_pkg::ST_IDLE);

  dcr_pat_ram #(
    .DEPTH (PAT_DEPTH),
    .W     (DQ_W),
    .AW    (PAT_AW)
  ) u_pat (
    .i_clk     (i_clk),
    .i_we      (apb_wr & sel_pat),
    .i_waddr   (i_paddr[PAT_AW+1:2]),
    .i_wdata   (i_pwdata[DQ_W-1:0]),
    .i_raddr_a (i_paddr[PAT_AW+1:2]),
    .o_rdata_a (apb_pat),
    .i_raddr_b (beat_idx),
    .o_rdata_b (beat_data)
  );

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ck_q  <= 1'b0;
      st_q  <= dcr_pkg::ST_IDLE;
      h_q   <= 5'h00;
      lat_q <= 4'h0;
    end
    else
    begin
      ck_q  <= link_s.ck;
      st_q  <= st_d;
      h_q   <= h_d;
      lat_q <= lat_d;
    end
  end

  // Command fields
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cmd_long_q <= 1'b0;
      col_q      <= 8'h00;
      long_q     <= 1'b0;
    end
    else if (rd_first)
      cmd_long_q <= link_s.cmd_addr[5];
    else if (cas_done)
    begin
      col_q  <= {link_s.cmd_addr, 2'b00};
      long_q <= ctrl_q.otf_enable ? cmd_long_q : ctrl_q.long_burst;
    end
  end

  // Pins change only on link edges
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dqs_q    <= 1'b0;
      dqs_oe_q <= 1'b0;
      dq_q     <= '0;
      dq_oe_q  <= 1'b0;
    end
    else if (ck_edge)
    begin
      dqs_q    <= dqs_d;
      dqs_oe_q <= in_burst_d;
      dq_q     <= (st_d == dcr_pkg::ST_DATA) ? beat_data : '0;
      dq_oe_q  <= (st_d == dcr_pkg::ST_DATA);
    end
  end

  // Software registers
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctrl_q    <= dcr_pkg::CTRL_RESET;
      refused_q <= 1'b0;
      count_q   <= 16'h0000;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      if (apb_wr & sel_ctrl)
        ctrl_q <= dcr_pkg::dcr_ctrl_t'(i_pwdata[7:0]);
      refused_q <= refuse | (refused_q & ~clr_refused);
      if (burst_done)
        count_q <= count_q + 16'h0001;
      if (apb_setup)
      begin
        prdata_q  <= rd_word;
        pslverr_q <= ~map_hit;
      end
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = 1'b1;
  assign o_pslverr = pslverr_q;
  assign o_dqs_t   = dqs_q;
  assign o_dqs_c   = ~dqs_q;
  assign o_dqs_oe  = dqs_oe_q;
  assign o_dq      = dq_q;
  assign o_dq_oe   = dq_oe_q;

  // Helper: link rises since the command completed
  logic [3:0] rise_cnt_q;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rise_cnt_q <= 4'h0;
    else if (cas_done)
      rise_cnt_q <= 4'h0;
    else if (ck_rise)
      rise_cnt_q <= rise_cnt_q + 4'h1;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  burst_start_a: assert property (
    rd_first |=> st_q == dcr_pkg::ST_CAS2)
    else $error("Read command did not start a burst");
  no_interrupt_a: assert property (
    (st_q == dcr_pkg::ST_DATA) && !(ck_edge && h_q == beat_last)
    |=> st_q == dcr_pkg::ST_DATA)
    else $error("Burst left data phase early");
  static_pre_a: assert property (
    (st_q == dcr_pkg::ST_PRE) && !ctrl_q.toggle_preamble |-> !o_dqs_t)
    else $error("Static preamble strobe toggled");
  pre_length_a: assert property (
    $rose(st_q == dcr_pkg::ST_PRE) |-> h_q == 5'h00 ##1
    (st_q == dcr_pkg::ST_PRE)[*3])
    else $error("Preamble too short");
  post_end_a: assert property (
    (st_q == dcr_pkg::ST_POST) && ck_edge &&
    h_q == (ctrl_q.ext_postamble ? 5'h02 : 5'h00)
    |=> st_q == dcr_pkg::ST_IDLE ##0 !o_dqs_oe)
    else $error("Postamble length wrong");
  col_align_a: assert property (
    cas_done |=> col_q[1:0] == 2'b00 &&
    col_q[7:2] == $past(link_s.cmd_addr))
    else $error("Burst column not a multiple of four");
  latency_a: assert property (
    $rose(st_q == dcr_pkg::ST_DATA) |-> rise_cnt_q == lat_eff)
    else $error("First data not at read latency");
  first_bit_a: assert property (
    $rose(st_q == dcr_pkg::ST_DATA) |-> o_dqs_t && o_dq_oe && o_dqs_oe)
    else $error("First bit not on rising strobe");
  edge_data_a: assert property (
    (st_q == dcr_pkg::ST_DATA) && $past(st_q) == dcr_pkg::ST_DATA &&
    $changed(h_q) |-> $changed(o_dqs_t))
    else $error("Data beat without strobe edge");
  long_burst_c: cover property (burst_done && long_q);
  ext_post_c:   cover property (burst_done && ctrl_q.ext_postamble);
  refused_c:    cover property (refuse);
  toggle_pre_c: cover property ((st_q == dcr_pkg::ST_PRE) && o_dqs_t);
endmodule

// ---- bench/dcr_host.sv ----
// Host controller model: link clock and read commands
`timescale 1ns/10ps
module dcr_host (
  input  wire logic       i_clk,
  input  wire logic       i_dqs_oe,
  output logic            o_ck,
  output logic            o_sel,
  output logic      [5:0] o_cmd_addr
);
  logic e0;

  // Only reads are sent: no activate, precharge, refresh or power-down
  initial
  begin
    o_ck       = 1'b0;
    o_sel      = 1'b0;
    o_cmd_addr = 6'h3F;
    e0         = 1'b0;
  end

  // One link half cycle is four system clocks
  task automatic half();
    repeat (4) @(posedge i_clk);
    o_ck <= ~o_ck;
  endtask

  // Link clock runs only within the frame
  task automatic send_read(input logic [5:0] c1, input logic [5:0] c2,
                           input logic extra);
    logic seen;
    seen = 1'b0;
    @(posedge i_clk);
    o_sel      <= 1'b1;
    o_cmd_addr <= c1;
    half();
    half();
    o_cmd_addr <= c2;
    half();
    e0 <= 1'b1;
    half();
    o_sel      <= extra;
    o_cmd_addr <= extra ? c1 : ~c2;
    half();
    half();
    o_cmd_addr <= extra ? c2 : ~c2;
    half();
    half();
    o_sel      <= 1'b0;
    o_cmd_addr <= c2 ^ 6'h3F;
    for (int n = 0; n < 200 && !(seen && !i_dqs_oe); n++)
    begin
      seen = seen | i_dqs_oe;
      half();
      half();
    end
    e0 <= 1'b0;
  endtask
endmodule

// ---- bench/dcr_top_tb.sv ----
// Self-checking bench for the burst-read core
`timescale 1ns/10ps
module dcr_top_tb;
  logic        clk, arst_n, psel, penable, pwrite, ck, sel;
  logic        pready, pslverr, dqs_t, dqs_c, dqs_oe, dq_oe, prev_t;
  logic [7:0]  paddr, dq;
  logic [5:0]  cmd;
  logic [31:0] pwdata, prdata;
  logic [7:0]  beats[$];
  int          errors, compares, pre_n, pre_tg, post_n, lat, nburst;

  dcr_top #(.DQ_W(8), .PAT_DEPTH(16)) dut_u (
    .i_clk(clk), .i_arst_n(arst_n), .i_paddr(paddr), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_ck(ck), .i_cmd_sel(sel), .i_cmd_addr(cmd), .o_dqs_t(dqs_t),
    .o_dqs_c(dqs_c), .o_dqs_oe(dqs_oe), .o_dq(dq), .o_dq_oe(dq_oe));

  dcr_host host_u (.i_clk(clk), .i_dqs_oe(dqs_oe), .o_ck(ck), .o_sel(sel),
                   .o_cmd_addr(cmd));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim();
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One APB transfer; a read compares data, both compare the error flag
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic e_exp);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    if (!w)
      chk("prdata", d, prdata);
    chk("pslverr", {31'h0, e_exp}, {31'h0, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Strobe and data watcher
  always @(posedge clk)
  begin
    if (dqs_oe && !dq_oe && beats.size() == 0)
    begin
      pre_n++;
      if (dqs_t != prev_t)
        pre_tg++;
    end
    if (dqs_oe && !dq_oe && beats.size() > 0)
      post_n++;
    if (dq_oe && dqs_t != prev_t)
      beats.push_back(dq);
    if (host_u.e0 && beats.size() == 0)
      lat++;
    if (dqs_oe)
      chk("dqs_c", {31'h0, ~dqs_t}, {31'h0, dqs_c});
    prev_t = dqs_t;
  end

  task automatic burst(input logic [31:0] ctrl, input logic lng,
                       input logic extra);
    int   rd_lat;
    int   nb;
    logic lx;
    rd_lat = (ctrl[3:0] < 3) ? 3 : int'(ctrl[3:0]);
    lx = ctrl[4] ? lng : ctrl[5];
    nb = lx ? 32 : 16;
    acc(1'b1, dcr_pkg::OFF_CTRL, ctrl, 1'b0);
    beats.delete();
    pre_n = 0;
    pre_tg = 0;
    post_n = 0;
    lat = 0;
    host_u.send_read({lng, dcr_pkg::OP_READ}, 6'h05, extra);
    repeat (8) @(posedge clk);
    nburst++;
    chk("beats", nb, beats.size());
    foreach (beats[i])
      chk("dq", 32'h0000_00A0 + ((20 + i) % 16), {24'h0, beats[i]});
    chk("preamble", 16, pre_n);
    chk("pre_toggle", {31'h0, ctrl[6]}, pre_tg != 0);
    chk("postamble", ctrl[7] ? 12 : 4, post_n);
    chk("latency", 1, lat >= 8 * rd_lat + 2 &&
        lat <= 8 * rd_lat + 6);
    acc(1'b0, dcr_pkg::OFF_STAT, 32'h0000_1400 | (lx << 2) | (extra << 1),
        1'b0);
    acc(1'b0, dcr_pkg::OFF_COUNT, nburst, 1'b0);
    if (extra)
    begin
      acc(1'b1, dcr_pkg::OFF_STAT, 32'h0000_0002, 1'b0);
      acc(1'b0, dcr_pkg::OFF_STAT, 32'h0000_1400 | (lx << 2), 1'b0);
    end
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    prev_t = 1'b0;
    errors = 0;
    compares = 0;
    nburst = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1'b0, dcr_pkg::OFF_CTRL, 32'h0000_0006, 1'b0);
    acc(1'b0, dcr_pkg::OFF_STAT, 32'h0000_0000, 1'b0);
    acc(1'b0, dcr_pkg::OFF_COUNT, 32'h0000_0000, 1'b0);
    acc(1'b1, 8'h3C, 32'h0000_00FF, 1'b1);
    acc(1'b0, 8'h3C, 32'h0000_0000, 1'b1);
    acc(1'b0, 8'h41, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 16; i++)
      acc(1'b1, 8'(8'h40 + 4 * i), 32'h0000_00A0 + i, 1'b0);
    for (int i = 0; i < 16; i++)
      acc(1'b0, 8'(8'h40 + 4 * i), 32'h0000_00A0 + i, 1'b0);
    burst(32'h0000_0006, 1'b1, 1'b0);
    burst(32'h0000_00D8, 1'b1, 1'b0);
    burst(32'h0000_0021, 1'b0, 1'b0);
    burst(32'h0000_0013, 1'b0, 1'b1);
    end_sim();
  end
endmodule
